// [include/ssr_pkg.sv]
// Package for the speed search and auto restart sequencer
package ssr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_SEARCH_ENABLE = 8'h00;
    localparam logic [7:0] OFF_CUR_LIMIT = 8'h04;
    localparam logic [7:0] OFF_PROP_GAIN = 8'h08;
    localparam logic [7:0] OFF_INT_GAIN = 8'h0c;
    localparam logic [7:0] OFF_OUT_FUNC = 8'h10;
    localparam logic [7:0] OFF_RETRY = 8'h14;
    localparam logic [7:0] OFF_DELAY = 8'h18;
    localparam logic [7:0] OFF_RATED_CUR = 8'h1c;
    localparam logic [7:0] OFF_CTRL = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
    localparam logic [7:0] OFF_FREQ = 8'h30;
    localparam logic [7:0] OFF_VOLT = 8'h34;
    // Search enable field bits
    localparam int EN_ACCEL = 0;
    localparam int EN_FAULT_RESET = 1;
    localparam int EN_POWER_FAIL = 2;
    localparam int EN_POWER_ON = 3;
    // Reset values and limits
    localparam logic [3:0] RST_SEARCH_ENABLE = 4'h0;
    localparam logic [7:0] RST_CUR_LIMIT = 8'h64;
    localparam logic [7:0] CUR_LIMIT_MIN = 8'h50;
    localparam logic [7:0] CUR_LIMIT_MAX = 8'hc8;
    localparam logic [13:0] RST_PROP_GAIN = 14'h0064;
    localparam logic [13:0] RST_INT_GAIN = 14'h00c8;
    localparam logic [13:0] GAIN_MAX = 14'h270f;
    localparam logic [4:0] RST_OUT_FUNC = 5'h0c;
    localparam logic [4:0] RST_RELAY_FUNC = 5'h11;
    localparam logic [4:0] FUNC_SEARCH_ACTIVE = 5'h0f;
    localparam logic [3:0] RST_RETRY = 4'h0;
    localparam logic [3:0] RETRY_MAX = 4'ha;
    localparam logic [9:0] RST_DELAY_TENTHS = 10'h00a;
    localparam logic [9:0] DELAY_MAX_TENTHS = 10'h258;
    localparam logic [15:0] RST_RATED_CUR = 16'h0064;
    localparam logic [15:0] NOMINAL_VOLT = 16'hffff;
    // Timing
    localparam int CLK_HZ = 50000000;
    localparam int RIDE_THROUGH_US = 15000;
    localparam int RIDE_THROUGH_CYC = RIDE_THROUGH_US * (CLK_HZ / 1000000);
    localparam int TENTH_SEC_MS = 100;
    localparam int TENTH_SEC_CYC = TENTH_SEC_MS * (CLK_HZ / 1000);
    localparam int GOOD_RUN_S = 30;
    localparam int GOOD_RUN_TENTHS = GOOD_RUN_S * 10;
    // Interrupt status bits
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_RESTART = 1;
    localparam int IRQ_SEARCH_DONE = 2;
    localparam int IRQ_EXHAUSTED = 3;
    // Trip causes
    typedef struct packed {
        logic low_voltage_trip;
        logic emergency_stop_input;
        logic overheat;
        logic hardware_trip;
        logic other;
    } ssr_trip_t;
    // Sequencer states
    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_SEARCH, ST_TRIPPED, ST_DELAY, ST_LATCHED}
        ssr_state_t;
    // Whole module state
    typedef struct packed {
        ssr_state_t st;
        logic [3:0] search_enable_field;
        logic [7:0] search_current_limit;
        logic [13:0] search_prop_gain;
        logic [13:0] search_integral_gain;
        logic [4:0] output_terminal_function;
        logic [4:0] relay_function;
        logic [3:0] restart_retry_count;
        logic [3:0] retries_left;
        logic [9:0] restart_delay;
        logic [15:0] motor_rated_current;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [15:0] freq;
        logic [15:0] volt;
        logic [15:0] saved_freq;
        logic [31:0] integ;
        logic [31:0] tick;
        logic [9:0] tenths;
        logic good_run;
        logic [31:0] outage;
        logic low_voltage_trip;
        logic auto_ok;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
        logic mo;
        logic relay;
    } ssr_state_s_t;
endpackage

// [rtl/ssr_top.sv]
// Speed search and auto restart sequencer with AHB-Lite registers
`timescale 1ns/1ps
module ssr_top
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic POWER_OK,
    input wire logic [15:0] OUT_CURRENT,
    input wire logic [15:0] CMD_FREQ,
    input wire logic RUN_CMD,
    input wire logic POWER_ON_START,
    input wire logic RESTART_AFTER_RESET,
    input wire logic FAULT_RESET,
    input wire ssr_pkg::ssr_trip_t TRIP_IN,
    output logic [15:0] FREQ_OUT,
    output logic [15:0] VOLT_OUT,
    output logic OUTPUT_ON,
    output logic SEARCH_ACTIVE,
    output logic MULTI_FUNCTION_OUTPUT,
    output logic MULTI_FUNCTION_RELAY,
    output logic IRQ
);
    ssr_pkg::ssr_state_s_t s;
    ssr_pkg::ssr_state_s_t next_s;
    logic [31:0] cur_lim;
    logic over_lim;
    logic [31:0] err;
    logic [31:0] pi;
    logic [3:0] ev;
    logic wr;
    logic trip_any;
    logic no_restart;
    logic [3:0] w4;

    // Current limit scaled from rated current percentage
    always_comb
    begin
        cur_lim = (32'(s.motor_rated_current) * 32'(s.search_current_limit)) / 32'd100;
        over_lim = 32'(OUT_CURRENT) > cur_lim;
        err = 32'(ssr_pkg::NOMINAL_VOLT) - 32'(s.volt);
        pi = ((err * 32'(s.search_prop_gain)) >> 16) + (s.integ >> 16);
        trip_any = |TRIP_IN;
        no_restart = TRIP_IN.low_voltage_trip | TRIP_IN.emergency_stop_input
            | TRIP_IN.overheat | TRIP_IN.hardware_trip;
        wr = s.ap_valid & s.ap_write;
        w4 = HWDATA[3:0];
    end

    // Main next-state logic
    always_comb
    begin
        next_s = s;
        ev = 4'h0;
        // Bus address phase capture
        next_s.ap_valid = HSEL & HREADY & HTRANS[1];
        next_s.ap_write = HWRITE;
        next_s.ap_addr = HADDR[7:0];
        // Register writes; out-of-range values leave the register unchanged
        if (wr)
        begin
            case (s.ap_addr)
                ssr_pkg::OFF_SEARCH_ENABLE: next_s.search_enable_field = w4;
                ssr_pkg::OFF_CUR_LIMIT:
                    if (HWDATA[7:0] >= ssr_pkg::CUR_LIMIT_MIN
                        && HWDATA[7:0] <= ssr_pkg::CUR_LIMIT_MAX)
                        next_s.search_current_limit = HWDATA[7:0];
                ssr_pkg::OFF_PROP_GAIN:
                    if (HWDATA[13:0] <= ssr_pkg::GAIN_MAX)
                        next_s.search_prop_gain = HWDATA[13:0];
                ssr_pkg::OFF_INT_GAIN:
                    if (HWDATA[13:0] <= ssr_pkg::GAIN_MAX)
                        next_s.search_integral_gain = HWDATA[13:0];
                ssr_pkg::OFF_OUT_FUNC:
                begin
                    next_s.output_terminal_function = HWDATA[4:0];
                    next_s.relay_function = HWDATA[12:8];
                end
                ssr_pkg::OFF_RETRY:
                    if (w4 <= ssr_pkg::RETRY_MAX)
                        next_s.restart_retry_count = w4;
                ssr_pkg::OFF_DELAY:
                    if (HWDATA[9:0] <= ssr_pkg::DELAY_MAX_TENTHS)
                        next_s.restart_delay = HWDATA[9:0];
                ssr_pkg::OFF_RATED_CUR: next_s.motor_rated_current = HWDATA[15:0];
                ssr_pkg::OFF_IRQ_MASK: next_s.irq_mask = w4;
                default: ;
            endcase
        end
        // Tenth-second time base
        if (s.tick >= 32'(ssr_pkg::TENTH_SEC_CYC - 1))
            next_s.tick = 32'h0;
        else
            next_s.tick = s.tick + 32'h1;
        // Ride-through: short outages do not trip
        if (POWER_OK)
            next_s.outage = 32'h0;
        else if (s.outage < 32'(ssr_pkg::RIDE_THROUGH_CYC))
            next_s.outage = s.outage + 32'h1;
        // Good-run window restores retries
        if (s.good_run && s.tick == 32'h0)
        begin
            if (s.tenths >= 10'(ssr_pkg::GOOD_RUN_TENTHS - 1))
            begin
                next_s.retries_left = s.restart_retry_count;
                next_s.good_run = 1'b0;
            end
            else
                next_s.tenths = s.tenths + 10'h1;
        end
        // Sequencer
        case (s.st)
            ssr_pkg::ST_IDLE:
            begin
                next_s.freq = 16'h0;
                next_s.volt = 16'h0;
                if (RUN_CMD && !trip_any)
                begin
                    // Search only for enabled start events
                    if ((POWER_ON_START && s.search_enable_field[ssr_pkg::EN_POWER_ON])
                        || s.search_enable_field[ssr_pkg::EN_ACCEL])
                    begin
                        next_s.freq = CMD_FREQ;
                        next_s.integ = 32'h0;
                        next_s.st = ssr_pkg::ST_SEARCH;
                    end
                    else
                        next_s.st = ssr_pkg::ST_RUN;
                end
            end
            ssr_pkg::ST_RUN:
            begin
                next_s.volt = ssr_pkg::NOMINAL_VOLT;
                if (s.freq < CMD_FREQ)
                    next_s.freq = s.freq + 16'h1;
                else if (s.freq > CMD_FREQ)
                    next_s.freq = s.freq - 16'h1;
                if (!RUN_CMD)
                    next_s.st = ssr_pkg::ST_IDLE;
            end
            ssr_pkg::ST_SEARCH:
            begin
                if (over_lim)
                begin
                    if (s.freq != 16'h0)
                        next_s.freq = s.freq - 16'h1;
                end
                else
                begin
                    next_s.integ = s.integ + err * 32'(s.search_integral_gain);
                    if (32'(s.volt) + pi >= 32'(ssr_pkg::NOMINAL_VOLT))
                        next_s.volt = ssr_pkg::NOMINAL_VOLT;
                    else
                        next_s.volt = s.volt + pi[15:0] + 16'h1;
                end
                if (s.volt == ssr_pkg::NOMINAL_VOLT && !over_lim)
                begin
                    next_s.st = ssr_pkg::ST_RUN;
                    ev[ssr_pkg::IRQ_SEARCH_DONE] = 1'b1;
                end
            end
            ssr_pkg::ST_TRIPPED, ssr_pkg::ST_LATCHED:
            begin
                next_s.freq = 16'h0;
                next_s.volt = 16'h0;
                if (FAULT_RESET)
                begin
                    next_s.retries_left = s.restart_retry_count;
                    next_s.low_voltage_trip = 1'b0;
                    if (RESTART_AFTER_RESET && RUN_CMD
                        && s.search_enable_field[ssr_pkg::EN_FAULT_RESET])
                    begin
                        next_s.freq = s.saved_freq;
                        next_s.st = ssr_pkg::ST_SEARCH;
                    end
                    else
                        next_s.st = ssr_pkg::ST_IDLE;
                end
                else if (s.st == ssr_pkg::ST_TRIPPED && s.low_voltage_trip && POWER_OK)
                begin
                    // Power returned: search from the saved frequency if EN_POWER_FAIL is set, else run up from zero
                    next_s.low_voltage_trip = 1'b0;
                    if (s.search_enable_field[ssr_pkg::EN_POWER_FAIL])
                    begin
                        next_s.freq = s.saved_freq;
                        next_s.integ = 32'h0;
                        next_s.st = ssr_pkg::ST_SEARCH;
                    end
                    else
                        next_s.st = ssr_pkg::ST_RUN;
                end
                else if (s.st == ssr_pkg::ST_TRIPPED && s.auto_ok)
                begin
                    next_s.tenths = 10'h0;
                    next_s.st = ssr_pkg::ST_DELAY;
                end
            end
            ssr_pkg::ST_DELAY:
            begin
                if (s.tick == 32'h0)
                    next_s.tenths = s.tenths + 10'h1;
                if (s.tenths >= s.restart_delay)
                begin
                    next_s.retries_left = s.retries_left - 4'h1;
                    next_s.freq = s.saved_freq;
                    next_s.volt = 16'h0;
                    next_s.integ = 32'h0;
                    next_s.tenths = 10'h0;
                    next_s.good_run = 1'b1;
                    next_s.st = ssr_pkg::ST_SEARCH;
                    ev[ssr_pkg::IRQ_RESTART] = 1'b1;
                end
                if (FAULT_RESET)
                begin
                    next_s.retries_left = s.restart_retry_count;
                    next_s.st = ssr_pkg::ST_IDLE;
                end
            end
            default: next_s.st = ssr_pkg::ST_IDLE;
        endcase
        // A fault reset reloads the remaining retries in any state, idle included
        if (FAULT_RESET)
        begin
            next_s.retries_left = s.restart_retry_count;
        end
        // Trips override sequencing while running
        if ((s.st == ssr_pkg::ST_RUN || s.st == ssr_pkg::ST_SEARCH)
            && (trip_any || s.outage >= 32'(ssr_pkg::RIDE_THROUGH_CYC)))
        begin
            next_s.saved_freq = s.freq;
            next_s.freq = 16'h0;
            next_s.volt = 16'h0;
            next_s.good_run = 1'b0;
            next_s.low_voltage_trip = ~POWER_OK | TRIP_IN.low_voltage_trip;
            ev[ssr_pkg::IRQ_TRIP] = 1'b1;
            if (no_restart || s.retries_left == 4'h0)
            begin
                next_s.auto_ok = 1'b0;
                next_s.st = (POWER_OK && !TRIP_IN.low_voltage_trip)
                    ? ssr_pkg::ST_LATCHED : ssr_pkg::ST_TRIPPED;
                if (!no_restart)
                    ev[ssr_pkg::IRQ_EXHAUSTED] = 1'b1;
            end
            else
            begin
                next_s.auto_ok = 1'b1;
                next_s.st = ssr_pkg::ST_TRIPPED;
            end
        end
        // Search-active indication on programmable outputs
        next_s.mo = next_s.st == ssr_pkg::ST_SEARCH
            && s.output_terminal_function == ssr_pkg::FUNC_SEARCH_ACTIVE;
        next_s.relay = next_s.st == ssr_pkg::ST_SEARCH
            && s.relay_function == ssr_pkg::FUNC_SEARCH_ACTIVE;
        // Sticky interrupt status, set wins over write-one clear
        next_s.irq_stat = (s.irq_stat & ~((wr && s.ap_addr == ssr_pkg::OFF_IRQ_STAT)
            ? w4 : 4'h0)) | ev;
        // Read data for the data phase
        case (HADDR[7:0])
            ssr_pkg::OFF_SEARCH_ENABLE: next_s.rdata = {28'h0, s.search_enable_field};
            ssr_pkg::OFF_CUR_LIMIT: next_s.rdata = {24'h0, s.search_current_limit};
            ssr_pkg::OFF_PROP_GAIN: next_s.rdata = {18'h0, s.search_prop_gain};
            ssr_pkg::OFF_INT_GAIN: next_s.rdata = {18'h0, s.search_integral_gain};
            ssr_pkg::OFF_OUT_FUNC:
                next_s.rdata = {19'h0, s.relay_function, 3'h0, s.output_terminal_function};
            ssr_pkg::OFF_RETRY: next_s.rdata = {24'h0, s.retries_left, s.restart_retry_count};
            ssr_pkg::OFF_DELAY: next_s.rdata = {22'h0, s.restart_delay};
            ssr_pkg::OFF_RATED_CUR: next_s.rdata = {16'h0, s.motor_rated_current};
            ssr_pkg::OFF_STATUS:
                next_s.rdata = {26'h0, s.low_voltage_trip, s.auto_ok, 1'b0, s.st};
            ssr_pkg::OFF_IRQ_STAT: next_s.rdata = {28'h0, s.irq_stat};
            ssr_pkg::OFF_IRQ_MASK: next_s.rdata = {28'h0, s.irq_mask};
            ssr_pkg::OFF_FREQ: next_s.rdata = {16'h0, s.freq};
            ssr_pkg::OFF_VOLT: next_s.rdata = {16'h0, s.volt};
            default: next_s.rdata = 32'h0;
        endcase
    end

    // State register with clock enable
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            s <= '0;
            s.st <= ssr_pkg::ST_IDLE;
            s.search_enable_field <= ssr_pkg::RST_SEARCH_ENABLE;
            s.search_current_limit <= ssr_pkg::RST_CUR_LIMIT;
            s.search_prop_gain <= ssr_pkg::RST_PROP_GAIN;
            s.search_integral_gain <= ssr_pkg::RST_INT_GAIN;
            s.output_terminal_function <= ssr_pkg::RST_OUT_FUNC;
            s.relay_function <= ssr_pkg::RST_RELAY_FUNC;
            s.restart_retry_count <= ssr_pkg::RST_RETRY;
            s.retries_left <= ssr_pkg::RST_RETRY;
            s.restart_delay <= ssr_pkg::RST_DELAY_TENTHS;
            s.motor_rated_current <= ssr_pkg::RST_RATED_CUR;
        end
        else if (CE)
            s <= next_s;
    end

    // Outputs
    assign HRDATA = s.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign FREQ_OUT = s.freq;
    assign VOLT_OUT = s.volt;
    assign OUTPUT_ON = s.st == ssr_pkg::ST_RUN || s.st == ssr_pkg::ST_SEARCH;
    assign SEARCH_ACTIVE = s.st == ssr_pkg::ST_SEARCH;
    assign MULTI_FUNCTION_OUTPUT = s.mo;
    assign MULTI_FUNCTION_RELAY = s.relay;
    assign IRQ = |(s.irq_stat & s.irq_mask);
endmodule

// [sim/ssr_motor_model.sv]
// Motor load model turning drive output into measured current
`timescale 1ns/1ps
module ssr_motor_model #(parameter logic [15:0] RATED = 16'h0064)
(
    input wire logic clk,
    input wire logic output_on,
    input wire logic [15:0] volt,
    input wire logic heavy,
    output logic [15:0] current
);
    // Current tracks voltage; a jammed shaft draws twice rated current
    always_ff @(posedge clk)
    begin
        if (!output_on)
            current <= 16'h0000;
        else if (heavy)
            current <= RATED + RATED;
        else
            current <= {10'h000, volt[15:10]};
    end
endmodule

// [sim/ssr_top_chk.sv]
// Assertion checker for the speed search and auto restart sequencer
`timescale 1ns/1ps
module ssr_chk #(parameter logic [15:0] LIM_CUR = 16'h0064)
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic POWER_OK,
    input wire logic [15:0] OUT_CURRENT,
    input wire logic RUN_CMD,
    input wire ssr_pkg::ssr_trip_t TRIP_IN,
    input wire logic [15:0] FREQ_OUT,
    input wire logic [15:0] VOLT_OUT,
    input wire logic OUTPUT_ON,
    input wire logic SEARCH_ACTIVE,
    input wire logic MULTI_FUNCTION_OUTPUT,
    input wire logic MULTI_FUNCTION_RELAY
);
    logic [31:0] outage;
    // Length of the present supply outage in cycles
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST || POWER_OK)
            outage <= 32'h0;
        else
            outage <= outage + 32'h1;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    property p_trip_off;
        CE && TRIP_IN != 5'h00 |=> !OUTPUT_ON && FREQ_OUT == 16'h0000 && VOLT_OUT == 16'h0000;
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("Output on after trip");
    property p_mfo;
        MULTI_FUNCTION_OUTPUT |-> SEARCH_ACTIVE || $past(SEARCH_ACTIVE);
    endproperty
    a_mfo: assert property (p_mfo) else $error("Output flag without search");
    property p_relay;
        MULTI_FUNCTION_RELAY |-> SEARCH_ACTIVE || $past(SEARCH_ACTIVE);
    endproperty
    a_relay: assert property (p_relay) else $error("Relay flag without search");
    property p_overcur;
        CE && SEARCH_ACTIVE && OUT_CURRENT > LIM_CUR |=> VOLT_OUT <= $past(VOLT_OUT)
            && (FREQ_OUT < $past(FREQ_OUT) || $past(FREQ_OUT) == 16'h0000);
    endproperty
    a_overcur: assert property (p_overcur) else $error("No backoff on overcurrent");
    property p_undercur;
        CE && SEARCH_ACTIVE && OUT_CURRENT < LIM_CUR |=> !SEARCH_ACTIVE
            || (VOLT_OUT >= $past(VOLT_OUT) && FREQ_OUT >= $past(FREQ_OUT));
    endproperty
    a_undercur: assert property (p_undercur) else $error("No recovery under limit");
    property p_done;
        $fell(SEARCH_ACTIVE) && OUTPUT_ON |-> $past(VOLT_OUT) == 16'hffff || VOLT_OUT == 16'hffff;
    endproperty
    a_done: assert property (p_done) else $error("Search ended below nominal");
    property p_ride;
        CE && RUN_CMD && OUTPUT_ON && !POWER_OK && TRIP_IN == 5'h00 && outage < 32'd1000
            |=> OUTPUT_ON;
    endproperty
    a_ride: assert property (p_ride) else $error("Short outage stopped output");
    property p_no_restart;
        CE && (TRIP_IN.emergency_stop_input || TRIP_IN.overheat || TRIP_IN.hardware_trip)
            |=> !OUTPUT_ON [*8];
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("Restart after hard trip");
    property p_volt_off;
        !OUTPUT_ON |-> VOLT_OUT == 16'h0000;
    endproperty
    a_volt_off: assert property (p_volt_off) else $error("Voltage while output off");
    c_search: cover property ($rose(SEARCH_ACTIVE));
    c_trip: cover property (TRIP_IN.other);
    c_outage: cover property (outage == 32'd100);
endmodule
bind ssr_top ssr_chk u_chk (.SYS_CLK, .RST, .CE, .POWER_OK, .OUT_CURRENT, .RUN_CMD, .TRIP_IN,
    .FREQ_OUT, .VOLT_OUT, .OUTPUT_ON, .SEARCH_ACTIVE, .MULTI_FUNCTION_OUTPUT,
    .MULTI_FUNCTION_RELAY);

// [sim/test_speed_search_auto_restart.sv]
// Self-checking bench for the speed search and auto restart sequencer
`timescale 1ns/1ps
module test_speed_search_auto_restart;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d;} ssr_row_t;
    logic SYS_CLK, RST, CE, HSEL, HWRITE, POWER_OK, RUN_CMD, POWER_ON_START, heavy;
    logic RESTART_AFTER_RESET, FAULT_RESET, HREADYOUT, HRESP, OUTPUT_ON, SEARCH_ACTIVE, IRQ;
    logic MULTI_FUNCTION_OUTPUT, MULTI_FUNCTION_RELAY;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [15:0] OUT_CURRENT, CMD_FREQ, FREQ_OUT, VOLT_OUT, f0;
    ssr_pkg::ssr_trip_t TRIP_IN;
    logic [4:0] cause[4] = '{5'h08, 5'h04, 5'h02, 5'h01};
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    ssr_row_t rows[$] = '{'{1'h0, 8'h00, 32'h0}, '{1'h0, 8'h04, 32'h64}, '{1'h0, 8'h08, 32'h64},
        '{1'h0, 8'h0c, 32'hc8}, '{1'h0, 8'h10, 32'h110c}, '{1'h0, 8'h14, 32'h0},
        '{1'h0, 8'h18, 32'ha}, '{1'h0, 8'h1c, 32'h64}, '{1'h0, 8'h2c, 32'h0},
        '{1'h0, 8'h40, 32'h0}, '{1'h1, 8'h04, 32'h4f}, '{1'h1, 8'h04, 32'hc9},
        '{1'h1, 8'h08, 32'h2710}, '{1'h1, 8'h14, 32'hb}, '{1'h1, 8'h18, 32'h259},
        '{1'h0, 8'h04, 32'h64}, '{1'h0, 8'h08, 32'h64}, '{1'h0, 8'h14, 32'h0},
        '{1'h0, 8'h18, 32'ha}, '{1'h1, 8'h04, 32'h50}, '{1'h0, 8'h04, 32'h50},
        '{1'h1, 8'h04, 32'h64}, '{1'h1, 8'h00, 32'h5}, '{1'h1, 8'h10, 32'hf0f},
        '{1'h1, 8'h18, 32'h0}, '{1'h1, 8'h14, 32'h2}, '{1'h1, 8'h1c, 32'h64},
        '{1'h1, 8'h2c, 32'hf}, '{1'h1, 8'h20, 32'hff}, '{1'h0, 8'h00, 32'h5},
        '{1'h0, 8'h10, 32'hf0f}, '{1'h0, 8'h18, 32'h0}, '{1'h0, 8'h20, 32'h0}};
    ssr_top DUT (.SYS_CLK, .RST, .CE, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .POWER_OK, .OUT_CURRENT, .CMD_FREQ,
        .RUN_CMD, .POWER_ON_START, .RESTART_AFTER_RESET, .FAULT_RESET, .TRIP_IN, .FREQ_OUT,
        .VOLT_OUT, .OUTPUT_ON, .SEARCH_ACTIVE, .MULTI_FUNCTION_OUTPUT, .MULTI_FUNCTION_RELAY,
        .IRQ);
    ssr_motor_model u_motor (.clk(SYS_CLK), .output_on(OUTPUT_ON), .volt(VOLT_OUT),
        .heavy(heavy), .current(OUT_CURRENT));
    // Clock at 50 MHz
    initial
    begin
        SYS_CLK = 1'h0;
        forever
            #10 SYS_CLK = ~SYS_CLK;
    end
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single AHB-Lite word transfer, waiting on ready in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge SYS_CLK);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'h1)
            @(posedge SYS_CLK);
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'h1)
            @(posedge SYS_CLK);
        r = HRDATA;
    endtask
    // Bounded wait: 0 search flag, 1 output on, 2 frequency at command
    task automatic wait_for(input int sel, input logic lvl, input int lim);
        int n;
        n = 0;
        while (n < lim && lvl !== (sel == 0 ? SEARCH_ACTIVE : sel == 1 ? OUTPUT_ON
            : FREQ_OUT === CMD_FREQ))
        begin
            @(posedge SYS_CLK);
            n++;
        end
        check(32'(n < lim), 32'h1);
    endtask
    task automatic trip(input logic [4:0] c);
        @(posedge SYS_CLK);
        TRIP_IN <= c;
        @(posedge SYS_CLK);
        TRIP_IN <= 5'h00;
    endtask
    task automatic clear_fault();
        @(posedge SYS_CLK);
        RUN_CMD <= 1'h0;
        FAULT_RESET <= 1'h1;
        @(posedge SYS_CLK);
        FAULT_RESET <= 1'h0;
    endtask
    task automatic do_reset();
        RST <= 1'h1;
        repeat (16)
            @(posedge SYS_CLK);
        RST <= 1'h0;
    endtask
    // Hang guard
    always @(posedge SYS_CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    // Main sequence
    initial
    begin
        {RST, HSEL, HWRITE, RUN_CMD, POWER_ON_START, heavy} = 6'h20;
        {RESTART_AFTER_RESET, FAULT_RESET, CE, POWER_OK} = 4'h3;
        {HADDR, HWDATA, HTRANS, HSIZE, TRIP_IN} = {64'h0, 2'h0, 3'h2, 5'h00};
        CMD_FREQ = 16'h0040;
        do_reset();
        foreach (rows[i])
        begin
            bus(rows[i].w, rows[i].a, rows[i].d, rd);
            if (!rows[i].w)
                check(rd, rows[i].d);
        end
        clear_fault();
        RUN_CMD <= 1'h1;
        wait_for(0, 1'h1, 20);
        repeat (2)
            @(posedge SYS_CLK);
        check({MULTI_FUNCTION_OUTPUT, MULTI_FUNCTION_RELAY}, 32'h3);
        wait_for(0, 1'h0, 4000);
        check(VOLT_OUT, 32'hffff);
        wait_for(2, 1'h1, 20000);
        POWER_OK <= 1'h0;
        repeat (100)
            @(posedge SYS_CLK);
        check(OUTPUT_ON, 32'h1);
        trip(5'h10);
        repeat (3)
            @(posedge SYS_CLK);
        check({OUTPUT_ON, FREQ_OUT}, 32'h0);
        POWER_OK <= 1'h1;
        wait_for(0, 1'h1, 20);
        @(posedge SYS_CLK);
        f0 = FREQ_OUT;
        check(f0, CMD_FREQ);
        heavy <= 1'h1;
        repeat (8)
            @(posedge SYS_CLK);
        check(32'(FREQ_OUT < f0), 32'h1);
        heavy <= 1'h0;
        wait_for(0, 1'h0, 4000);
        for (int k = 0; k < 3; k++)
        begin
            trip(5'h01);
            if (k < 2)
            begin
                wait_for(0, 1'h1, 50);
                bus(1'h0, 8'h14, 32'h0, rd);
                check(rd, 32'h02 + 32'(16 * (1 - k)));
                wait_for(0, 1'h0, 4000);
            end
        end
        repeat (30)
            @(posedge SYS_CLK);
        bus(1'h0, 8'h24, 32'h0, rd);
        check({OUTPUT_ON, rd[2:0]}, 32'h5);
        check(IRQ, 32'h1);
        bus(1'h1, 8'h2c, 32'h0, rd);
        @(posedge SYS_CLK);
        check(IRQ, 32'h0);
        bus(1'h1, 8'h28, 32'hf, rd);
        bus(1'h1, 8'h2c, 32'hf, rd);
        bus(1'h0, 8'h28, 32'h0, rd);
        check(32'(IRQ), 32'h0);
        check(rd, 32'h0);
        clear_fault();
        bus(1'h0, 8'h14, 32'h0, rd);
        check(rd, 32'h22);
        foreach (cause[i])
        begin
            bus(1'h1, 8'h14, (i == 3) ? 32'h0 : 32'h2, rd);
            clear_fault();
            RUN_CMD <= 1'h1;
            wait_for(0, 1'h1, 20);
            wait_for(0, 1'h0, 4000);
            trip(cause[i]);
            repeat (30)
                @(posedge SYS_CLK);
            check(OUTPUT_ON, 32'h0);
            clear_fault();
        end
        do_reset();
        bus(1'h0, 8'h00, 32'h0, rd);
        check(32'(IRQ), 32'h0);
        check(rd, 32'h0);
        RUN_CMD <= 1'h1;
        wait_for(1, 1'h1, 20);
        check(SEARCH_ACTIVE, 32'h0);
        // Clock enable low must freeze the ramp
        CE <= 1'h0;
        @(posedge SYS_CLK);
        f0 = FREQ_OUT;
        repeat (4)
            @(posedge SYS_CLK);
        check(FREQ_OUT, f0);
        CE <= 1'h1;
        summarize();
    end
endmodule
